// ==== dv/serial_port_and_parallel_switch_inputs_tb.sv ====
`timescale 1ns/1ps
module serial_port_and_parallel_switch_inputs_tb;
  logic clk = 1'b0;
  logic arst_n = 1'b0;
  logic cs_n, sclk, si, so, so_oe_n;
  logic [3:0] par = 4'h0;
  logic [7:0] sw;
  logic [3:0] pair;
  logic [3:0] e_now = 4'h0;
  logic [7:0] s_now = 8'h00;
  logic [15:0] q;
  int failures = 0;
  int compares = 0;
  int cycles = 0;
  always #20 clk = ~clk;
  spi_host_model i_spi_host_model (.i_clk(clk), .i_so(so), .o_cs_n(cs_n), .o_sclk(sclk),
    .o_si(si));
  serial_port_switch_inputs i_serial_port_switch_inputs (.I_CLK(clk), .I_ARST_N(arst_n),
    .I_CS_N(cs_n), .I_SCLK(sclk), .I_SI(si), .I_PARALLEL_IN_ONE(par[0]),
    .I_PARALLEL_IN_THREE(par[1]), .I_PARALLEL_IN_FIVE(par[2]),
    .I_PARALLEL_IN_SEVEN(par[3]), .O_SO(so), .O_SO_OE_N(so_oe_n),
    .O_OCTAL_LOW_SIDE_SWITCH(sw), .O_PAIR_EN(pair));
  task automatic w(input int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp) begin
      failures++;
      $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  function automatic logic [7:0] exp_sw(input logic [3:0] p, input logic [3:0] e,
    input logic [7:0] s);
    for (int k = 0; k < 4; k++) begin
      exp_sw[2*k] = p[k] | s[2*k];
      exp_sw[2*k+1] = e[k] ? exp_sw[2*k] : s[2*k+1];
    end
  endfunction
  // drive each parallel input alone and compare all eight outputs
  task automatic t_par;
    for (int k = 0; k < 4; k++) begin
      par = 4'h1 << k;
      w(5);
      chk({8'h00, sw}, {8'h00, exp_sw(par, e_now, s_now)});
      par = 4'h0;
      w(5);
    end
    chk({8'h00, sw}, {8'h00, exp_sw(4'h0, e_now, s_now)});
  endtask
  // one frame; readback must show state from before it
  task automatic frame(input logic [15:0] d, input int n);
    logic [15:0] r;
    r = {exp_sw(par, e_now, s_now), 4'h0, e_now};
    i_spi_host_model.xfer(d, n, q);
    chk(q, r >> (16 - n));
    if (n == 16) begin
      e_now = d[3:0];
      s_now = d[15:8];
    end
    w(6);
    chk({12'h000, pair}, {12'h000, e_now});
    chk({8'h00, sw}, {8'h00, exp_sw(par, e_now, s_now)});
  endtask
  // clock edges while deselected must leave the output shifter alone
  task automatic t_stray;
    logic keep;
    keep = so;
    i_spi_host_model.stray(14);
    w(4);
    chk({15'h0000, so}, {15'h0000, keep});
  endtask
  task automatic wrap_up;
    $display("counts compares=%0d failures=%0d", compares, failures);
    if (failures == 0 && compares > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      failures++;
      wrap_up();
    end
  end
  initial begin
    w(3);
    arst_n = 1'b1;
    w(3);
    chk({sw, 3'h0, so_oe_n, pair}, 16'h0010);
    $display("test reset done");
    t_par();
    $display("test unpaired done");
    frame(16'h000f, 16);
    t_par();
    $display("test paired done");
    frame(16'h5a05, 16);
    t_par();
    $display("test serial on done");
    frame(16'hff0a, 8);
    $display("test short frame done");
    t_stray();
    frame(16'h0003, 16);
    $display("test deselected clock done");
    wrap_up();
  end
endmodule

// ==== dv/spi_host_model.sv ====
`timescale 1ns/1ps
module spi_host_model (
  input wire logic i_clk,
  input wire logic i_so,
  output logic o_cs_n,
  output logic o_sclk,
  output logic o_si
);
  initial begin
    o_cs_n = 1'b1;
    o_sclk = 1'b0;
    o_si = 1'b0;
  end
  task automatic w(input int n);
    repeat (n) @(negedge i_clk);
  endtask
  // msb first, data read back just before each fall
  task automatic xfer(input logic [15:0] d, input int n, output logic [15:0] q);
    q = 16'h0000;
    w(1);
    o_cs_n = 1'b0;
    for (int i = 0; i < n; i++) begin
      o_si = d[15 - i];
      w(4);
      o_sclk = 1'b1;
      w(3);
      q = {q[14:0], i_so};
      w(1);
      o_sclk = 1'b0;
    end
    w(4);
    o_cs_n = 1'b1;
    o_si = ~o_si;
    w(8);
  endtask
  // clock edges with chip select high
  task automatic stray(input int n);
    for (int i = 0; i < n; i++) begin
      o_si = i[0];
      w(4);
      o_sclk = ~o_sclk;
    end
  endtask
endmodule

// ==== src/serial_port_switch_inputs.sv ====
`timescale 1ns/1ps
module serial_port_switch_inputs (
  input wire logic I_CLK,
  input wire logic I_ARST_N,
  input wire logic I_CS_N,
  input wire logic I_SCLK,
  input wire logic I_SI,
  input wire logic I_PARALLEL_IN_ONE,
  input wire logic I_PARALLEL_IN_THREE,
  input wire logic I_PARALLEL_IN_FIVE,
  input wire logic I_PARALLEL_IN_SEVEN,
  output logic O_SO,
  output logic O_SO_OE_N,
  output logic [7:0] O_OCTAL_LOW_SIDE_SWITCH,
  output logic [3:0] O_PAIR_EN
);

  logic [1:0] cs_sync;
  logic [1:0] sclk_sync;
  logic [1:0] si_sync;
  logic [1:0] par_sync [4];
  logic cs_d;
  logic sclk_d;
  logic [15:0] rx;
  logic [15:0] tx;
  logic [15:0] cfg;
  logic [4:0] cnt;
  logic cs_s;
  logic sclk_s;
  logic si_s;
  logic sclk_rise;
  logic sclk_fall;
  logic cs_fall;
  logic cs_rise;
  logic [3:0] par_raw;

  switch_ctrl_if sw_bus ();

  assign par_raw = {I_PARALLEL_IN_SEVEN, I_PARALLEL_IN_FIVE, I_PARALLEL_IN_THREE,
                    I_PARALLEL_IN_ONE};

  // chip select resets to deselected, as the pad pull-up holds it high
  always_ff @(posedge I_CLK or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      cs_sync <= spsw_pkg::CS_SYNC_RESET;
      cs_d <= 1'b1;
    end else begin
      cs_sync <= {cs_sync[0], I_CS_N};
      cs_d <= cs_sync[1];
    end
  end

  always_ff @(posedge I_CLK or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      sclk_sync <= spsw_pkg::PIN_SYNC_RESET;
      sclk_d <= 1'b0;
    end else begin
      sclk_sync <= {sclk_sync[0], I_SCLK};
      sclk_d <= sclk_sync[1];
    end
  end

  always_ff @(posedge I_CLK or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      si_sync <= spsw_pkg::PIN_SYNC_RESET;
    end else begin
      si_sync <= {si_sync[0], I_SI};
    end
  end

  always_ff @(posedge I_CLK or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      for (int i = 0; i < spsw_pkg::NUM_PAIRS; i++) begin
        par_sync[i] <= spsw_pkg::PIN_SYNC_RESET;
      end
    end else begin
      for (int i = 0; i < spsw_pkg::NUM_PAIRS; i++) begin
        par_sync[i] <= {par_sync[i][0], par_raw[i]};
      end
    end
  end

  // edges of a synchronised level against its one-cycle delayed copy
  function automatic logic edge_up(input logic lvl, input logic prev);
    return lvl & ~prev;
  endfunction

  function automatic logic edge_down(input logic lvl, input logic prev);
    return ~lvl & prev;
  endfunction

  // a frame counts only with exactly the agreed number of clock rises
  function automatic logic frame_len_ok(input logic [4:0] bits);
    return bits == 5'(spsw_pkg::FRAME_BITS);
  endfunction

  assign cs_s = cs_sync[1];
  assign sclk_s = sclk_sync[1];
  assign si_s = si_sync[1];
  assign sclk_rise = edge_up(sclk_s, sclk_d);
  assign sclk_fall = edge_down(sclk_s, sclk_d);
  assign cs_fall = edge_down(cs_s, cs_d);
  assign cs_rise = edge_up(cs_s, cs_d);

  // receive shifter, msb first
  always_ff @(posedge I_CLK or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      rx <= spsw_pkg::SHIFT_RESET;
    end else if (sclk_rise && !cs_s && !cs_fall) begin
      rx <= {rx[14:0], si_s};
    end
  end

  // bit counter, saturates so an overlong frame never wraps back to a legal length
  always_ff @(posedge I_CLK or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      cnt <= spsw_pkg::CNT_RESET;
    end else if (cs_fall) begin
      cnt <= spsw_pkg::CNT_RESET;
    end else if (sclk_rise && !cs_s && cnt != spsw_pkg::CNT_MAX) begin
      cnt <= cnt + 5'h01;
    end
  end

  // a frame of exactly the right length is taken on deselect
  always_ff @(posedge I_CLK or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      cfg <= spsw_pkg::CFG_RESET;
    end else if (cs_rise && frame_len_ok(cnt)) begin
      cfg <= rx;
    end
  end

  // transmit shifter, loaded with switch state on select
  always_ff @(posedge I_CLK or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      tx <= spsw_pkg::SHIFT_RESET;
    end else if (cs_fall) begin
      tx <= {sw_bus.sw_on, 4'h0, cfg[spsw_pkg::PAIR_LSB +: 4]};
    end else if (sclk_fall && !cs_s) begin
      tx <= {tx[14:0], 1'b0};
    end
  end

  assign O_SO = tx[15];
  assign O_SO_OE_N = cs_s;
  assign O_OCTAL_LOW_SIDE_SWITCH = sw_bus.sw_on;
  assign O_PAIR_EN = cfg[spsw_pkg::PAIR_LSB +: 4];

  always_comb begin
    for (int i = 0; i < spsw_pkg::NUM_PAIRS; i++) begin
      sw_bus.par_in[i] = par_sync[i][1];
    end
  end
  assign sw_bus.pair_en = cfg[spsw_pkg::PAIR_LSB +: 4];
  assign sw_bus.ser_on = cfg[spsw_pkg::SER_ON_LSB +: 8];

  switch_mapper u_mapper (
    .i_clk(I_CLK),
    .i_arst_n(I_ARST_N),
    .bus(sw_bus.mapper)
  );

  a_rise_sample: assert property (@(posedge I_CLK) disable iff (!I_ARST_N)
    (sclk_rise && !cs_s && !cs_fall) |=> rx[0] == $past(si_s) && rx[15:1] == $past(rx[14:0]))
    else $error("serial input not sampled on clock rise");
  a_idle_hold: assert property (@(posedge I_CLK) disable iff (!I_ARST_N)
    cs_s |=> $stable(rx) && $stable(cnt) && $stable(tx))
    else $error("shift state changed while deselected");
  a_tx_shift: assert property (@(posedge I_CLK) disable iff (!I_ARST_N)
    (sclk_fall && !cs_s && !cs_fall) |=> tx == {$past(tx[14:0]), 1'b0})
    else $error("output bit not shifted on clock fall");
  a_oe_select: assert property (@(posedge I_CLK) disable iff (!I_ARST_N)
    O_SO_OE_N == cs_s)
    else $error("serial output driven while deselected");
  a_frame_commit: assert property (@(posedge I_CLK) disable iff (!I_ARST_N)
    (cs_rise && cnt == 5'(spsw_pkg::FRAME_BITS)) |=> O_PAIR_EN == $past(rx[3:0]))
    else $error("complete frame not committed");
  a_short_frame: assert property (@(posedge I_CLK) disable iff (!I_ARST_N)
    (cs_rise && cnt != 5'(spsw_pkg::FRAME_BITS)) |=> $stable(cfg))
    else $error("bad length frame committed");
  // bit counter clears and transmit shifter loads on select; counter and shifters otherwise move only on their own clock edge
  a_cnt_clear: assert property (@(posedge I_CLK) disable iff (!I_ARST_N)
    cs_fall |=> cnt == spsw_pkg::CNT_RESET)
    else $error("bit count not cleared on select");
  a_cnt_step: assert property (@(posedge I_CLK) disable iff (!I_ARST_N)
    (sclk_rise && !cs_s && !cs_fall && cnt != spsw_pkg::CNT_MAX)
      |=> cnt == $past(cnt) + 5'h01)
    else $error("bit count not advanced on clock rise");
  a_cnt_fall_hold: assert property (@(posedge I_CLK) disable iff (!I_ARST_N)
    (sclk_fall && !cs_fall) |=> $stable(cnt))
    else $error("bit count moved on clock fall");
  a_rx_fall_hold: assert property (@(posedge I_CLK) disable iff (!I_ARST_N)
    sclk_fall |=> $stable(rx))
    else $error("serial input sampled on clock fall");
  a_tx_rise_hold: assert property (@(posedge I_CLK) disable iff (!I_ARST_N)
    (sclk_rise && !cs_fall) |=> $stable(tx))
    else $error("output shifter moved on clock rise");
  a_tx_load: assert property (@(posedge I_CLK) disable iff (!I_ARST_N)
    cs_fall |=> tx == {$past(O_OCTAL_LOW_SIDE_SWITCH), 4'h0, $past(O_PAIR_EN)})
    else $error("output frame not loaded on select");
  a_so_first_bit: assert property (@(posedge I_CLK) disable iff (!I_ARST_N)
    cs_fall |=> O_SO == $past(O_OCTAL_LOW_SIDE_SWITCH[7]))
    else $error("first output bit wrong");
  a_ser_commit: assert property (@(posedge I_CLK) disable iff (!I_ARST_N)
    (cs_rise && frame_len_ok(cnt)) |=> sw_bus.ser_on == $past(rx[15:8]))
    else $error("serial switch bits not committed");
  a_cfg_select_hold: assert property (@(posedge I_CLK) disable iff (!I_ARST_N)
    !cs_s |=> $stable(cfg))
    else $error("configuration changed while selected");

endmodule

// ==== src/spsw_pkg.sv ====
package spsw_pkg;
  localparam int FRAME_BITS = 16;
  localparam int SER_ON_LSB = 8;
  localparam int PAIR_LSB = 0;
  localparam int NUM_PAIRS = 4;
  localparam int NUM_SWITCHES = 8;
  localparam int SYNC_STAGES = 2;
  localparam logic [15:0] CFG_RESET = 16'h0000;
  localparam logic [15:0] SHIFT_RESET = 16'h0000;
  localparam logic [4:0] CNT_RESET = 5'h00;
  localparam logic [4:0] CNT_MAX = 5'h1f;
  localparam logic [1:0] CS_SYNC_RESET = 2'h3;
  localparam logic [1:0] PIN_SYNC_RESET = 2'h0;
  localparam logic [7:0] SWITCH_RESET = 8'h00;
endpackage

// ==== src/switch_ctrl_if.sv ====
`timescale 1ns/1ps
interface switch_ctrl_if;
  logic [3:0] par_in;
  logic [3:0] pair_en;
  logic [7:0] ser_on;
  logic [7:0] sw_on;
  modport ctrl (output par_in, output pair_en, output ser_on, input sw_on);
  modport mapper (input par_in, input pair_en, input ser_on, output sw_on);
endinterface

// ==== src/switch_mapper.sv ====
`timescale 1ns/1ps
module switch_mapper (
  input wire logic i_clk,
  input wire logic i_arst_n,
  switch_ctrl_if.mapper bus
);

  // odd output follows its input ORed with its serial bit, even output copies it only when paired
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      bus.sw_on <= spsw_pkg::SWITCH_RESET;
    end else begin
      for (int p = 0; p < spsw_pkg::NUM_PAIRS; p++) begin
        bus.sw_on[2*p] <= bus.par_in[p] | bus.ser_on[2*p];
        if (bus.pair_en[p]) begin
          bus.sw_on[2*p+1] <= bus.par_in[p] | bus.ser_on[2*p];
        end else begin
          bus.sw_on[2*p+1] <= bus.ser_on[2*p+1];
        end
      end
    end
  end

  a_out_one_follow: assert property (@(posedge i_clk) disable iff (!i_arst_n)
    !bus.ser_on[0] |=> bus.sw_on[0] == $past(bus.par_in[0]))
    else $error("output 1 does not follow input one");
  a_pair_one_two: assert property (@(posedge i_clk) disable iff (!i_arst_n)
    (bus.pair_en[0] && !bus.ser_on[0]) |=> bus.sw_on[1] == $past(bus.par_in[0]) && bus.sw_on[0] == bus.sw_on[1])
    else $error("outputs 1 and 2 not driven together");
  a_pair_three_four: assert property (@(posedge i_clk) disable iff (!i_arst_n)
    (bus.pair_en[1] && !bus.ser_on[2]) |=> bus.sw_on[3] == $past(bus.par_in[1]) && bus.sw_on[2] == bus.sw_on[3])
    else $error("outputs 3 and 4 not driven together");
  a_pair_five_six: assert property (@(posedge i_clk) disable iff (!i_arst_n)
    (bus.pair_en[2] && !bus.ser_on[4]) |=> bus.sw_on[5] == $past(bus.par_in[2]) && bus.sw_on[4] == bus.sw_on[5])
    else $error("outputs 5 and 6 not driven together");
  a_pair_seven_eight: assert property (@(posedge i_clk) disable iff (!i_arst_n)
    (bus.pair_en[3] && !bus.ser_on[6]) |=> bus.sw_on[7] == $past(bus.par_in[3]) && bus.sw_on[6] == bus.sw_on[7])
    else $error("outputs 7 and 8 not driven together");
  a_even_isolated: assert property (@(posedge i_clk) disable iff (!i_arst_n)
    (!bus.pair_en[0] && !bus.ser_on[1]) |=> !bus.sw_on[1])
    else $error("output 2 responds to input one while unpaired");

endmodule
